// [common/sdc_pkg.sv]
// package for the dual element core datapath: offsets, fields, types
package sdc_pkg;
  // ********************************
  // register offsets
  // ********************************
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_RSEL = 8'h08;
  localparam logic [7:0] OFF_RLO = 8'h0C;
  localparam logic [7:0] OFF_RHI = 8'h10;
  localparam logic [7:0] OFF_BITOP = 8'h14;
  localparam logic [7:0] OFF_UNIVERSAL_STATUS_REG = 8'h20;
  localparam logic [7:0] OFF_TPER = 8'h30;
  localparam logic [7:0] OFF_TCTL = 8'h34;
  localparam logic [7:0] OFF_STAT = 8'h38;
  localparam logic [7:0] OFF_DSEL = 8'h40;
  localparam logic [7:0] OFF_DI = 8'h44;
  localparam logic [7:0] OFF_DB = 8'h48;
  localparam logic [7:0] OFF_DL = 8'h4C;
  localparam logic [7:0] OFF_DM = 8'h50;
  localparam logic [7:0] OFF_XFER = 8'h54;
  localparam logic [7:0] OFF_PXLO = 8'h58;
  localparam logic [7:0] OFF_PXHI = 8'h5C;
  // ********************************
  // fields and reset values
  // ********************************
  localparam int MODE_PEY_EN = 0;
  localparam int MODE_SH_REG = 1;
  localparam int MODE_SH_DAG = 2;
  localparam int MODE_SH_MR = 3;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [1:0] TCTL_RST = 2'h0;
  localparam int TCTL_EN = 0;
  localparam int TCTL_PIN = 1;
  localparam int X_DM = 0;
  localparam int X_PM = 1;
  localparam int X_ST = 2;
  localparam int X_PX = 3;
  localparam int X_REG = 4;
  localparam int X_D1 = 8;
  localparam int X_D2 = 11;
  localparam int B_US = 3;
  localparam int B_TG = 5;
  localparam int BLK_LSB = 17;
  localparam int BLK_MSB = 18;
  // ********************************
  // types
  // ********************************
  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_SHL, OP_SHR, OP_MUL,
    OP_F16TO32, OP_F32TO16, OP_FNEG, OP_FABS, OP_TOEXT, OP_TOPX, OP_FROMPX, OP_PASS
  } sdc_op_t;
  typedef enum logic [2:0] {BIT_SET, BIT_CLR, BIT_TGL, BIT_TST, BIT_XOR} sdc_bitop_t;
  typedef enum logic [1:0] {W16, W32, W48, W64} sdc_width_t;
  typedef enum logic [1:0] {FS_IDLE = 2'b00, FS_HOLD = 2'b01, FS_WAIT1 = 2'b11, FS_WAIT2 = 2'b10} sdc_fstate_t;
  typedef struct packed {
    logic multi;
    logic [3:0] sb;
    logic [3:0] sa;
    logic [3:0] dst;
    sdc_op_t op;
  } sdc_instr_t;
  typedef struct packed {
    logic req;
    logic we;
    sdc_width_t width;
    logic [31:0] addr;
    logic [63:0] wdata;
  } sdc_mem_t;
endpackage : sdc_pkg

// [src/sdc_core.sv]
// dual element core datapath with address generators, cache, timer
`timescale 1ns/1ps
module sdc_core #(
  parameter int CACHE_N = 4
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output sdc_pkg::sdc_mem_t dm_req,
  input wire logic [63:0] dm_rdata,
  output sdc_pkg::sdc_mem_t pm_req,
  input wire logic [63:0] pm_rdata,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic fetch_async,
  output logic fetch_ready,
  output logic [47:0] instr_word,
  output sdc_pkg::sdc_width_t instr_len,
  output logic instr_valid,
  output logic fetch_fault,
  input wire logic iop_req,
  input wire logic [31:0] iop_addr,
  output logic iop_gnt,
  output logic timer_event,
  output logic general_pin_three,
  output logic general_pin_three_oe
);
  import sdc_pkg::*;

  localparam int CW = (CACHE_N > 1) ? $clog2(CACHE_N) : 1;
  if (CACHE_N < 2 || CACHE_N > 16 || (CACHE_N & (CACHE_N - 1)) != 0) begin : g_bad_cache
    $error("CACHE_N must be a power of two from 2 to 16");
  end

  // ********************************
  // functions
  // ********************************
  function automatic logic [15:0] f32to16(input logic [31:0] x);
    logic [7:0] e;
    e = x[30:23];
    if (e < 8'h71) f32to16 = {x[31], 15'h0000};
    else if (e > 8'h8E) f32to16 = {x[31], 5'h1F, 10'h000};
    else f32to16 = {x[31], 5'(e - 8'h70), x[22:13]};
  endfunction : f32to16

  function automatic logic [31:0] f16to32(input logic [15:0] h);
    if (h[14:10] == 5'h00) f16to32 = {h[15], 31'h00000000};
    else if (h[14:10] == 5'h1F) f16to32 = {h[15], 8'hFF, h[9:0], 13'h0000};
    else f16to32 = {h[15], 8'(h[14:10]) + 8'h70, h[9:0], 13'h0000};
  endfunction : f16to32

  function automatic logic [39:0] alu_f(input sdc_op_t op, input logic [39:0] a, input logic [39:0] b,
                                        input logic [63:0] px);
    case (op)
      OP_ADD: alu_f = {8'h00, a[31:0] + b[31:0]};
      OP_SUB: alu_f = {8'h00, a[31:0] - b[31:0]};
      OP_AND: alu_f = a & b;
      OP_OR: alu_f = a | b;
      OP_XOR: alu_f = a ^ b;
      OP_SHL: alu_f = a << b[5:0];
      OP_SHR: alu_f = a >> b[5:0];
      OP_MUL: alu_f = {8'h00, a[31:0] * b[31:0]};
      OP_F16TO32: alu_f = {8'h00, f16to32(a[15:0])};
      OP_F32TO16: alu_f = {24'h000000, f32to16(a[31:0])};
      OP_FNEG: alu_f = {a[39:32], ~a[31], a[30:0]};
      OP_FABS: alu_f = {a[39:32], 1'b0, a[30:0]};
      OP_TOEXT: alu_f = {a[31:0], 8'h00};
      OP_FROMPX: alu_f = px[39:0];
      default: alu_f = a;
    endcase
  endfunction : alu_f

  function automatic logic [31:0] circ(input logic [31:0] i, input logic [31:0] m,
                                       input logic [31:0] b, input logic [31:0] l);
    logic [31:0] n;
    n = i + m;
    if (l == 32'h00000000) circ = n;
    else if (!m[31] && n >= b + l) circ = n - l;
    else if (m[31] && n < b) circ = n + l;
    else circ = n;
  endfunction : circ

  function automatic logic [1:0] blk(input logic [31:0] a);
    blk = a[BLK_MSB:BLK_LSB];
  endfunction : blk

  function automatic sdc_width_t ilen(input logic [47:0] w);
    case (w[47:46])
      2'b01: ilen = W16;
      2'b10: ilen = W32;
      default: ilen = W48;
    endcase
  endfunction : ilen

  // ********************************
  // state
  // ********************************
  logic [39:0] rf_r [2][32];
  logic [79:0] mr_r [2][2];
  logic [31:0] di_r [32];
  logic [31:0] db_r [32];
  logic [31:0] dl_r [32];
  logic [31:0] dmod_r [32];
  logic [31:0] universal_status_reg_r [4];
  logic [31:0] ctag_r [CACHE_N];
  logic [47:0] cdat_r [CACHE_N];
  logic [CACHE_N-1:0] cval_r;
  logic [CW-1:0] cptr_r;
  logic [3:0] mode_r;
  logic [5:0] rsel_r;
  logic [4:0] dsel_r;
  logic [1:0] tctl_r;
  logic [31:0] tper_r;
  logic [31:0] tcnt_r;
  logic [63:0] px_r;
  logic tev_r;
  logic test_r;
  logic hit_r;
  logic ld_a_r;
  logic ld_b_r;
  logic [13:0] ld_x_r;
  logic ld_simd_r;
  sdc_fstate_t fs_r;
  logic [31:0] faddr_r;
  logic ffill_r;
  logic fasync_r;

  // ********************************
  // decode
  // ********************************
  wire act = avs_write & ~avs_waitrequest;
  wire [31:0] wd = avs_writedata;
  wire wr_mode = act && avs_address == OFF_MODE;
  wire do_ins = act && avs_address == OFF_INSTR;
  wire do_bit = act && avs_address == OFF_BITOP;
  wire do_x = act && avs_address == OFF_XFER;
  wire wr_stat = act && avs_address == OFF_STAT;
  wire pey_en = mode_r[MODE_PEY_EN];
  wire rbank = mode_r[MODE_SH_REG];
  wire dbank = mode_r[MODE_SH_DAG];
  wire mbank = mode_r[MODE_SH_MR];
  sdc_instr_t ins;
  assign ins = sdc_instr_t'(wd[16:0]);
  wire [3:0] xb = wd[X_REG +: 4];
  wire [3:0] xb1 = xb + 4'h1;
  wire [4:0] a1 = {dbank, 1'b0, wd[X_D1 +: 3]};
  wire [4:0] a2 = {dbank, 1'b1, wd[X_D2 +: 3]};
  wire xpx = wd[X_PX];
  wire wide = pey_en | xpx;
  wire tmr_exp = tctl_r[TCTL_EN] && tcnt_r == 32'h00000000;

  logic [39:0] opa [2];
  logic [39:0] opb [2];
  logic [39:0] res [2];
  logic [63:0] mul [2];
  for (genvar p = 0; p < 2; p++) begin : g_pe
    assign opa[p] = rf_r[p][{rbank, ins.sa}];
    assign opb[p] = rf_r[p][{rbank, ins.sb}];
    assign res[p] = alu_f(ins.op, opa[p], opb[p], px_r);
    assign mul[p] = opa[p][31:0] * opb[p][31:0];
  end

  // ********************************
  // universal bit operations
  // ********************************
  wire [2:0] bop = wd[2:0];
  wire [31:0] bmask = universal_status_reg_r[wd[B_US +: 2]];
  wire [1:0] btg = wd[B_TG +: 2];
  wire [31:0] bval = (btg == 2'd0) ? {28'h0000000, mode_r} : (btg == 2'd1) ? {30'h00000000, tctl_r} : tper_r;
  wire [31:0] bres = (bop == BIT_SET) ? (bval | bmask) :
                     (bop == BIT_CLR) ? (bval & ~bmask) : (bval ^ bmask);
  wire bchg = do_bit && (bop == BIT_SET || bop == BIT_CLR || bop == BIT_TGL);

  // ********************************
  // memory requests and fetch control
  // ********************************
  sdc_mem_t dm_nxt;
  sdc_mem_t pm_nxt;
  sdc_fstate_t fs_nxt;
  logic chit;
  logic [47:0] cword;
  wire pm_data = do_x & wd[X_PM];
  wire f_take = fs_r == FS_IDLE && fetch_valid;

  always_comb begin
    chit = 1'b0;
    cword = 48'h000000000000;
    for (int k = 0; k < CACHE_N; k++) begin
      if (cval_r[k] && ctag_r[k] == fetch_addr) begin
        chit = 1'b1;
        cword = cdat_r[k];
      end
    end
  end

  always_comb begin
    dm_nxt.req = do_x & wd[X_DM];
    dm_nxt.we = wd[X_ST];
    dm_nxt.width = wide ? W64 : W32;
    dm_nxt.addr = di_r[a1];
    dm_nxt.wdata = xpx ? px_r : {pey_en ? rf_r[1][{rbank, xb}][31:0] : 32'h00000000, rf_r[0][{rbank, xb}][31:0]};
    pm_nxt.req = pm_data;
    pm_nxt.we = wd[X_ST];
    pm_nxt.width = wide ? W64 : W32;
    pm_nxt.addr = di_r[a2];
    pm_nxt.wdata = xpx ? px_r : {pey_en ? rf_r[1][{rbank, xb1}][31:0] : 32'h00000000, rf_r[0][{rbank, xb1}][31:0]};
    fs_nxt = fs_r;
    case (fs_r)
      FS_IDLE: begin
        if (f_take && !pm_data) fs_nxt = FS_WAIT1;
        else if (f_take && !chit) fs_nxt = FS_HOLD;
      end
      FS_HOLD: if (!pm_data) fs_nxt = FS_WAIT1;
      FS_WAIT1: fs_nxt = FS_WAIT2;
      FS_WAIT2: fs_nxt = FS_IDLE;
      default: fs_nxt = FS_IDLE;
    endcase
    if (!pm_data && (fs_r == FS_HOLD || (f_take && !pm_data))) begin
      pm_nxt.req = 1'b1;
      pm_nxt.we = 1'b0;
      pm_nxt.width = W48;
      pm_nxt.addr = (fs_r == FS_HOLD) ? faddr_r : fetch_addr;
    end
  end

  wire iop_ok = iop_req && !(dm_nxt.req && blk(dm_nxt.addr) == blk(iop_addr)) &&
                !(pm_nxt.req && blk(pm_nxt.addr) == blk(iop_addr));

  // ********************************
  // register read mux
  // ********************************
  logic [31:0] rd_nxt;
  always_comb begin
    case (avs_address)
      OFF_MODE: rd_nxt = {28'h0000000, mode_r};
      OFF_RSEL: rd_nxt = {26'h0000000, rsel_r};
      OFF_RLO: rd_nxt = rf_r[rsel_r[5]][rsel_r[4:0]][31:0];
      OFF_RHI: rd_nxt = {24'h000000, rf_r[rsel_r[5]][rsel_r[4:0]][39:32]};
      OFF_UNIVERSAL_STATUS_REG, 8'h24, 8'h28, 8'h2C: rd_nxt = universal_status_reg_r[avs_address[3:2]];
      OFF_TPER: rd_nxt = tper_r;
      OFF_TCTL: rd_nxt = {30'h00000000, tctl_r};
      OFF_STAT: rd_nxt = {27'h0000000, pey_en, fetch_fault, hit_r, test_r, tev_r};
      OFF_DSEL: rd_nxt = {27'h0000000, dsel_r};
      OFF_DI: rd_nxt = di_r[dsel_r];
      OFF_DB: rd_nxt = db_r[dsel_r];
      OFF_DL: rd_nxt = dl_r[dsel_r];
      OFF_DM: rd_nxt = dmod_r[dsel_r];
      OFF_PXLO: rd_nxt = px_r[31:0];
      OFF_PXHI: rd_nxt = px_r[63:32];
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // ********************************
  // bus slave and control registers
  // ********************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      mode_r <= MODE_RST;
      tctl_r <= TCTL_RST;
      tper_r <= 32'h00000000;
      rsel_r <= 6'h00;
      dsel_r <= 5'h00;
      tev_r <= 1'b0;
      test_r <= 1'b0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      avs_readdata <= rd_nxt;
      if (wr_mode) mode_r <= wd[3:0];
      if (act && avs_address == OFF_TCTL) tctl_r <= wd[1:0];
      if (act && avs_address == OFF_TPER) tper_r <= wd;
      if (act && avs_address == OFF_RSEL) rsel_r <= wd[5:0];
      if (act && avs_address == OFF_DSEL) dsel_r <= wd[4:0];
      if (bchg && btg == 2'd0) mode_r <= bres[3:0];
      if (bchg && btg == 2'd1) tctl_r <= bres[1:0];
      if (bchg && btg == 2'd2) tper_r <= bres;
      if (do_bit && bop == BIT_TST) test_r <= (bval & bmask) == bmask;
      if (do_bit && bop == BIT_XOR) test_r <= (bval ^ bmask) == 32'h00000000;
      tev_r <= tmr_exp | (tev_r & ~(wr_stat & wd[0]));
    end
  end

  always_ff @(posedge clock) begin
    if (act && avs_address[7:4] == 4'h2) universal_status_reg_r[avs_address[3:2]] <= wd;
    if (act && avs_address == OFF_DB) db_r[dsel_r] <= wd;
    if (act && avs_address == OFF_DL) dl_r[dsel_r] <= wd;
    if (act && avs_address == OFF_DM) dmod_r[dsel_r] <= wd;
    if (act && avs_address == OFF_DI) di_r[dsel_r] <= wd;
    if (do_x && wd[X_DM]) di_r[a1] <= circ(di_r[a1], dmod_r[a1], db_r[a1], dl_r[a1]);
    if (do_x && wd[X_PM]) di_r[a2] <= circ(di_r[a2], dmod_r[a2], db_r[a2], dl_r[a2]);
  end

  // ********************************
  // register files, results, exchange
  // ********************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ld_a_r <= 1'b0;
      ld_b_r <= 1'b0;
      ld_x_r <= 14'h0000;
      ld_simd_r <= 1'b0;
      px_r <= 64'h0000000000000000;
    end else begin
      ld_a_r <= do_x & ~wd[X_ST] & (wd[X_DM] | wd[X_PM]);
      ld_b_r <= ld_a_r;
      if (do_x) ld_x_r <= wd[13:0];
      if (do_x) ld_simd_r <= pey_en;
      if (ld_b_r && ld_x_r[X_PX] && ld_x_r[X_PM]) px_r <= pm_rdata;
      if (ld_b_r && ld_x_r[X_PX] && !ld_x_r[X_PM] && ld_x_r[X_DM]) px_r <= dm_rdata;
      if (act && avs_address == OFF_PXLO) px_r[31:0] <= wd;
      if (act && avs_address == OFF_PXHI) px_r[63:32] <= wd;
      if (do_ins && ins.op == OP_TOPX) px_r <= {24'h000000, opa[0]};
    end
  end

  wire [3:0] lb = ld_x_r[X_REG +: 4];
  wire [3:0] lb1 = lb + 4'h1;
  always_ff @(posedge clock) begin
    if (ld_b_r && !ld_x_r[X_PX] && ld_x_r[X_DM]) begin
      rf_r[0][{rbank, lb}] <= {8'h00, dm_rdata[31:0]};
      if (ld_simd_r) rf_r[1][{rbank, lb}] <= {8'h00, dm_rdata[63:32]};
    end
    if (ld_b_r && !ld_x_r[X_PX] && ld_x_r[X_PM]) begin
      rf_r[0][{rbank, lb1}] <= {8'h00, pm_rdata[31:0]};
      if (ld_simd_r) rf_r[1][{rbank, lb1}] <= {8'h00, pm_rdata[63:32]};
    end
    for (int p = 0; p < 2; p++) begin
      if (do_ins && ins.op != OP_TOPX && (p == 0 || pey_en)) begin
        rf_r[p][{rbank, ins.dst}] <= res[p];
        if (ins.multi || ins.op == OP_MUL) mr_r[p][mbank] <= {16'h0000, mul[p]};
      end
    end
    if (act && avs_address == OFF_RLO) rf_r[rsel_r[5]][rsel_r[4:0]][31:0] <= wd;
    if (act && avs_address == OFF_RHI) rf_r[rsel_r[5]][rsel_r[4:0]][39:32] <= wd[7:0];
  end

  // ********************************
  // sequencer fetch and selective cache
  // ********************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fs_r <= FS_IDLE;
      faddr_r <= 32'h00000000;
      ffill_r <= 1'b0;
      fasync_r <= 1'b0;
      cval_r <= '0;
      cptr_r <= '0;
      hit_r <= 1'b0;
      fetch_ready <= 1'b1;
      instr_word <= 48'h000000000000;
      instr_len <= W48;
      instr_valid <= 1'b0;
      fetch_fault <= 1'b0;
    end else begin
      fs_r <= fs_nxt;
      fetch_ready <= fs_nxt == FS_IDLE;
      instr_valid <= 1'b0;
      fetch_fault <= 1'b0;
      if (f_take) begin
        faddr_r <= fetch_addr;
        ffill_r <= pm_data;
        fasync_r <= fetch_async;
        hit_r <= pm_data & chit;
      end
      if (f_take && pm_data && chit) begin
        instr_word <= cword;
        instr_len <= ilen(cword);
        instr_valid <= 1'b1;
      end
      if (fs_r == FS_WAIT2) begin
        instr_word <= pm_rdata[47:0];
        instr_len <= ilen(pm_rdata[47:0]);
        if (fasync_r && ilen(pm_rdata[47:0]) != W48) fetch_fault <= 1'b1;
        else instr_valid <= 1'b1;
        if (ffill_r) begin
          ctag_r[cptr_r] <= faddr_r;
          cdat_r[cptr_r] <= pm_rdata[47:0];
          cval_r[cptr_r] <= 1'b1;
          cptr_r <= cptr_r + 1'b1;
        end
      end
    end
  end

  // ********************************
  // memory ports, io grant, timer
  // ********************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dm_req <= '0;
      pm_req <= '0;
      iop_gnt <= 1'b0;
      tcnt_r <= 32'h00000000;
      timer_event <= 1'b0;
      general_pin_three <= 1'b0;
      general_pin_three_oe <= 1'b0;
    end else begin
      dm_req <= dm_nxt;
      pm_req <= pm_nxt;
      iop_gnt <= iop_ok;
      if (!tctl_r[TCTL_EN] || tmr_exp) tcnt_r <= tper_r;
      else tcnt_r <= tcnt_r - 32'h00000001;
      timer_event <= tmr_exp;
      general_pin_three <= tmr_exp & tctl_r[TCTL_PIN];
      general_pin_three_oe <= tctl_r[TCTL_PIN];
    end
  end
endmodule : sdc_core

// [testbench/sdc_mem_model.sv]
// memory block model answering one data bus of the core
`timescale 1ns/1ps
module sdc_mem_model (
  input wire logic clock,
  input sdc_pkg::sdc_mem_t req_in,
  output logic [63:0] rdata
);
  import sdc_pkg::*;
  initial rdata = 64'h0;
  always @(posedge clock) begin
    if (req_in.req && !req_in.we) begin
      rdata <= {~req_in.addr, req_in.addr};
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule : sdc_mem_model

// [testbench/sdc_core_sva.sv]
// checker: port properties of the core datapath
`timescale 1ns/1ps
module sdc_core_sva (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input sdc_pkg::sdc_mem_t dm_req,
  input sdc_pkg::sdc_mem_t pm_req,
  input wire logic fetch_valid,
  input wire logic fetch_ready,
  input wire logic [47:0] instr_word,
  input sdc_pkg::sdc_width_t instr_len,
  input wire logic instr_valid,
  input wire logic fetch_fault,
  input wire logic iop_req,
  input wire logic [31:0] iop_addr,
  input wire logic iop_gnt,
  input wire logic timer_event,
  input wire logic general_pin_three,
  input wire logic general_pin_three_oe
);
  import sdc_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic [1:0] io_blk = iop_addr[18:17];
  wire logic [1:0] ltag = instr_word[47:46];
  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  property p_fetch;
    fetch_valid && fetch_ready |=> !fetch_ready || instr_valid;
  endproperty
  property p_len;
    instr_valid |-> instr_len == (ltag == 2'b01 ? W16 : ltag == 2'b10 ? W32 : W48);
  endproperty
  property p_fault;
    fetch_fault |-> !instr_valid ##1 !instr_valid;
  endproperty
  property p_gnt;
    !$past(sys_rst) |-> iop_gnt == ($past(iop_req) && !(dm_req.req && dm_req.addr[18:17] == $past(io_blk)) &&
                                    !(pm_req.req && pm_req.addr[18:17] == $past(io_blk)));
  endproperty
  property p_gnt_cause;
    iop_gnt |-> $past(iop_req);
  endproperty
  property p_pin;
    general_pin_three |-> timer_event && general_pin_three_oe;
  endproperty
  property p_dm_pulse;
    dm_req.req |=> !dm_req.req;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state not single");
  a_fetch: assert property (p_fetch) else $error("fetch not taken");
  a_len: assert property (p_len) else $error("length decode wrong");
  a_fault: assert property (p_fault) else $error("faulted word delivered");
  a_gnt: assert property (p_gnt) else $error("io access not granted");
  a_gnt_cause: assert property (p_gnt_cause) else $error("grant without request");
  a_pin: assert property (p_pin) else $error("pin pulse without expiry");
  a_dm_pulse: assert property (p_dm_pulse) else $error("data request too long");
  c_instr: cover property (instr_valid);
  c_fault: cover property (fetch_fault);
  c_pin: cover property (general_pin_three);
endmodule : sdc_core_sva
bind sdc_core sdc_core_sva u_sva (.clock, .sys_rst, .avs_read, .avs_write, .avs_waitrequest, .dm_req,
  .pm_req, .fetch_valid, .fetch_ready, .instr_word, .instr_len, .instr_valid, .fetch_fault, .iop_req,
  .iop_addr, .iop_gnt, .timer_event, .general_pin_three, .general_pin_three_oe);

// [testbench/sdc_core_tb_top.sv]
// testbench: drives the core over avalon, fetch and io ports
`timescale 1ns/1ps
module sdc_core_tb_top;
  import sdc_pkg::*;
  logic clock, sys_rst, avs_read, avs_write, avs_waitrequest, fetch_valid, fetch_async, fetch_ready;
  logic instr_valid, fetch_fault, iop_req, iop_gnt, timer_event, general_pin_three, general_pin_three_oe;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, fetch_addr, iop_addr, rd, b, s;
  logic [31:0] v [4];
  logic [63:0] dm_rdata, pm_rdata;
  logic [47:0] instr_word;
  sdc_mem_t dm_req, pm_req;
  sdc_width_t instr_len;
  int error_cnt, check_count, op, m, k, n, p;
  sdc_core #(.CACHE_N(4)) DUT (.clock, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .dm_req, .dm_rdata, .pm_req, .pm_rdata, .fetch_valid, .fetch_addr,
    .fetch_async, .fetch_ready, .instr_word, .instr_len, .instr_valid, .fetch_fault, .iop_req, .iop_addr,
    .iop_gnt, .timer_event, .general_pin_three, .general_pin_three_oe);
  sdc_mem_model u_dm (.clock, .req_in(dm_req), .rdata(dm_rdata));
  sdc_mem_model u_pm (.clock, .req_in(pm_req), .rdata(pm_rdata));
  // ****************************
  // helpers
  // ****************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask : av
  task automatic wreg(input logic e, input logic [4:0] i, input logic [31:0] d);
    av(1'b1, OFF_RSEL, {26'h0, e, i});
    av(1'b1, OFF_RHI, 32'h0);
    av(1'b1, OFF_RLO, d);
  endtask : wreg
  task automatic rreg(input logic e, input logic [4:0] i);
    av(1'b1, OFF_RSEL, {26'h0, e, i});
    av(1'b0, OFF_RLO, 32'h0);
  endtask : rreg
  function automatic logic [31:0] alu(input int o, input logic [31:0] x, input logic [31:0] y);
    case (o)
      0: return x + y;
      1: return x - y;
      2: return x & y;
      3: return x | y;
      default: return x ^ y;
    endcase
  endfunction : alu
  function automatic logic [31:0] bop(input int o, input logic [31:0] t, input logic [31:0] u);
    case (o)
      0: return t | u;
      1: return t & ~u;
      2: return t ^ u;
      default: return t;
    endcase
  endfunction : bop
  task automatic fetch(input logic as, input logic [31:0] fa);
    logic [1:0] t;
    logic ef;
    t = ~fa[15:14];
    ef = as && t != 2'b11 && t != 2'b00;
    while (fetch_ready !== 1'b1) @(posedge clock);
    fetch_valid <= 1'b1;
    fetch_addr <= fa;
    fetch_async <= as;
    @(posedge clock);
    fetch_valid <= 1'b0;
    n = 0;
    while (instr_valid !== 1'b1 && fetch_fault !== 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
    end
    chk(fetch_fault, ef);
    if (!ef) begin
      chk(instr_word, {~fa[15:0], fa});
      chk(instr_len, (t == 2'b01) ? W16 : (t == 2'b10) ? W32 : W48);
    end
    @(posedge clock);
  endtask : fetch
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clock) begin
    iop_req <= $urandom_range(1);
    iop_addr <= $urandom;
  end
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    #(25 * 40000);
    error_cnt++;
    print_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    {avs_read, avs_write, fetch_valid, fetch_async} = 4'h0;
    {avs_address, avs_writedata, fetch_addr} = 72'h0;
    error_cnt = 0;
    check_count = 0;
    rd = $urandom(72551);
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    av(1'b0, OFF_MODE, 32'h0);
    chk(rd, MODE_RST);
    av(1'b0, OFF_STAT, 32'h0);
    chk(rd[4], 1'b0);
    av(1'b0, 8'hFC, 32'h0);
    chk(rd, 32'h0);
    wreg(1'b0, 5'h04, 32'h0000_1234);
    wreg(1'b0, 5'h14, 32'h0000_ABCD);
    rreg(1'b0, 5'h04);
    chk(rd, 32'h0000_1234);
    av(1'b1, OFF_MODE, 32'h2);
    av(1'b1, OFF_INSTR, 32'h0000_046F);
    rreg(1'b0, 5'h16);
    chk(rd, 32'h0000_ABCD);
    for (m = 0; m < 2; m++) begin
      av(1'b1, OFF_MODE, m);
      for (op = 0; op < 5; op++) begin
        foreach (v[j]) v[j] = $urandom;
        wreg(1'b0, 5'h01, v[0]);
        wreg(1'b0, 5'h02, v[1]);
        wreg(1'b1, 5'h01, v[2]);
        wreg(1'b1, 5'h02, v[3]);
        wreg(1'b1, 5'h03, v[3]);
        av(1'b1, OFF_INSTR, {15'h0, m[0], 4'h2, 4'h1, 4'h3, op[3:0]});
        rreg(1'b0, 5'h03);
        chk(rd, alu(op, v[0], v[1]));
        rreg(1'b1, 5'h03);
        chk(rd, (m == 1) ? alu(op, v[2], v[3]) : v[3]);
      end
    end
    for (op = 0; op < 5; op++) begin
      v[0] = $urandom;
      v[1] = $urandom;
      if (op == 3) v[0] = v[0] | v[1];
      if (op == 4) v[1] = v[0];
      av(1'b1, OFF_TPER, v[0]);
      av(1'b1, OFF_UNIVERSAL_STATUS_REG + 8'h04, v[1]);
      av(1'b1, OFF_BITOP, {25'h0, 2'h2, 2'h1, op[2:0]});
      av(1'b0, OFF_TPER, 32'h0);
      chk(rd, bop(op, v[0], v[1]));
      av(1'b0, OFF_STAT, 32'h0);
      chk(rd[1], op >= 3);
    end
    p = $urandom_range(6, 2);
    av(1'b1, OFF_TPER, p);
    av(1'b1, OFF_TCTL, 32'h3);
    while (timer_event !== 1'b1) @(posedge clock);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (timer_event !== 1'b1 && n < 50);
    chk(n, p + 1);
    chk(general_pin_three, 1'b1);
    chk(general_pin_three_oe, 1'b1);
    av(1'b1, OFF_TCTL, 32'h0);
    fetch(1'b1, 32'h0000_8000);
    fetch(1'b1, 32'h0000_0010);
    for (k = 0; k < 6; k++) fetch(1'b0, $urandom);
    av(1'b1, OFF_DSEL, 32'h8);
    av(1'b1, OFF_DI, 32'h200);
    av(1'b1, OFF_DL, 32'h0);
    av(1'b1, OFF_DM, 32'h0);
    for (k = 0; k < 2; k++) begin
      fork
        av(1'b1, OFF_XFER, 32'h0000_0002);
        begin
          @(posedge clock);
          fetch(1'b0, 32'h0000_0010);
        end
      join
      chk(n, k ? 1 : 4);
      av(1'b0, OFF_STAT, 32'h0);
      chk(rd[2], k);
    end
    av(1'b1, OFF_MODE, 32'h1);
    for (k = 0; k < 2; k++) begin
      s = $urandom_range(7);
      b = $urandom_range(4000);
      av(1'b1, OFF_DSEL, s);
      av(1'b1, OFF_DB, b);
      av(1'b1, OFF_DI, b + 32'h1);
      av(1'b1, OFF_DL, 32'h2);
      av(1'b1, OFF_DM, 32'h1);
      av(1'b1, OFF_XFER, {21'h0, s[2:0], 4'h5, 4'h1});
      av(1'b0, OFF_DI, 32'h0);
      chk(rd, b);
      rreg(1'b0, 5'h05);
      chk(rd, b + 32'h1);
      b = ~(b + 32'h1);
      rreg(1'b1, 5'h05);
      chk(rd, b);
    end
    print_verdict();
  end
endmodule : sdc_core_tb_top
